// >>> core/flash_read_regs.vh
// constants for the serial flash read master
`ifndef FLASH_READ_REGS_VH
`define FLASH_READ_REGS_VH

`define ST_IDLE        3'h0
`define ST_LEAD        3'h1
`define ST_CMD         3'h2
`define ST_READ        3'h3
`define ST_TAIL        3'h4

`define MODE_3PIN      2'h0
`define MODE_4PIN      2'h1
`define MODE_DUAL      2'h2
`define MODE_QUAD      2'h3

`define CMD_BITS       6'h20
`define TAIL_PERIODS   2'h2
`define MIN_PERIOD     9'h002
`define READ_CMD_RST   8'h03

`endif

// >>> core/sync_2ff.v
// two flip-flop synchroniser, one per bit
module sync_2ff #(
    parameter WIDTH = 4
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_reg;
            reg stable_reg;
            always @(posedge ref_clk) begin
                if (rst) begin
                    meta_reg   <= 1'b0;
                    stable_reg <= 1'b0;
                end else begin
                    meta_reg   <= async_in[i];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_out[i] = stable_reg;
        end
    endgenerate
endmodule // sync_2ff

// >>> core/flash_read_master.v
// serial flash read master: mode 0 clock, 1/2/4 line reads, word and frame events
`include "flash_read_regs.vh"
module flash_read_master (
    input  wire         ref_clk,
    input  wire         rst,
    input  wire         mm_req,
    input  wire [23:0]  mm_addr,
    input  wire [7:0]   read_cmd,
    input  wire [1:0]   lane_mode,
    input  wire [7:0]   clock_divide_factor,
    input  wire [6:0]   word_len_m1,
    input  wire [11:0]  word_count_m1,
    input  wire [1:0]   cs_to_data_delay_field,
    input  wire         word_irq_en,
    input  wire         frame_irq_en,
    input  wire [3:0]   d_in,
    output reg          sclk,
    output reg          cs_n,
    output reg  [3:0]   d_out,
    output reg  [3:0]   d_oe,
    output reg  [127:0] rdata,
    output reg          rdata_valid,
    output reg          word_irq,
    output reg          frame_irq,
    output reg          busy
);
    wire [3:0]   d_sync;
    reg  [2:0]   state_reg;
    reg  [8:0]   ph_reg;
    reg  [8:0]   period_reg;
    reg  [8:0]   hi_reg;
    reg  [1:0]   lead_cnt_reg;
    reg  [1:0]   tail_cnt_reg;
    reg  [5:0]   cmd_cnt_reg;
    reg  [31:0]  cmd_sh_reg;
    reg  [127:0] shift_reg;
    reg  [7:0]   bit_cnt_reg;
    reg  [12:0]  word_cnt_reg;
    reg  [1:0]   mode_reg;
    reg  [6:0]   len_reg;
    reg  [11:0]  count_reg;
    reg  [1:0]   dly_reg;
    reg          wirq_en_reg;
    reg          firq_en_reg;

    reg  [127:0] shift_next;
    reg  [7:0]   bits_next;
    reg  [3:0]   lanes_n;

    wire wrap      = (ph_reg == period_reg - 9'h001);
    wire fall_tick = (ph_reg == hi_reg);
    wire [8:0] ph_inc = wrap ? 9'h000 : ph_reg + 9'h001;

    // clock period in ref cycles for a divide factor
    function [8:0] period_of;
        input [7:0] f;
        begin
            if (f == 8'h00)
                period_of = `MIN_PERIOD;
            else
                period_of = {1'b0, f} + 9'h001;
        end
    endfunction

    // high time: half for zero/odd, f/2 for even
    function [8:0] high_of;
        input [7:0] f;
        begin
            if (f == 8'h00)
                high_of = 9'h001;
            else if (f[0])
                high_of = ({1'b0, f} + 9'h001) >> 1;
            else
                high_of = {2'b00, f[7:1]};
        end
    endfunction

    sync_2ff #(.WIDTH(4)) u_din_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in (d_in),
        .sync_out (d_sync)
    );

    // gather the bits of one falling edge per lane mode
    always @* begin
        lanes_n    = 4'h1;
        shift_next = shift_reg;
        case (mode_reg)
            `MODE_3PIN: begin
                shift_next = {shift_reg[126:0], d_sync[0]};
            end
            `MODE_4PIN: begin
                shift_next = {shift_reg[126:0], d_sync[1]};
            end
            `MODE_DUAL: begin
                lanes_n    = 4'h2;
                shift_next = {shift_reg[125:0], d_sync[1:0]};
            end
            `MODE_QUAD: begin
                lanes_n    = 4'h4;
                shift_next = {shift_reg[123:0], d_sync[3:0]};
            end
            default: begin
                shift_next = shift_reg;
            end
        endcase
        bits_next = bit_cnt_reg + {4'h0, lanes_n};
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            state_reg    <= `ST_IDLE;
            ph_reg       <= 9'h000;
            period_reg   <= `MIN_PERIOD;
            hi_reg       <= 9'h001;
            lead_cnt_reg <= 2'h0;
            tail_cnt_reg <= 2'h0;
            cmd_cnt_reg  <= 6'h00;
            cmd_sh_reg   <= 32'h00000000;
            shift_reg    <= 128'h0;
            bit_cnt_reg  <= 8'h00;
            word_cnt_reg <= 13'h0000;
            mode_reg     <= `MODE_3PIN;
            len_reg      <= 7'h00;
            count_reg    <= 12'h000;
            dly_reg      <= 2'h0;
            wirq_en_reg  <= 1'b0;
            firq_en_reg  <= 1'b0;
            sclk         <= 1'b0;
            cs_n         <= 1'b1;
            d_out        <= 4'h0;
            d_oe         <= 4'h0;
            rdata        <= 128'h0;
            rdata_valid  <= 1'b0;
            word_irq     <= 1'b0;
            frame_irq    <= 1'b0;
            busy         <= 1'b0;
        end else begin
            rdata_valid <= 1'b0;
            word_irq    <= 1'b0;
            frame_irq   <= 1'b0;
            case (state_reg)
                `ST_IDLE: begin
                    sclk  <= 1'b0;
                    cs_n  <= 1'b1;
                    d_oe  <= 4'h0;
                    busy  <= 1'b0;
                    if (mm_req) begin
                        mode_reg     <= lane_mode;
                        len_reg      <= word_len_m1;
                        count_reg    <= word_count_m1;
                        dly_reg      <= cs_to_data_delay_field;
                        wirq_en_reg  <= word_irq_en;
                        firq_en_reg  <= frame_irq_en;
                        period_reg   <= period_of(clock_divide_factor);
                        hi_reg       <= high_of(clock_divide_factor);
                        ph_reg       <= high_of(clock_divide_factor);
                        cmd_sh_reg   <= {read_cmd, mm_addr};
                        lead_cnt_reg <= 2'h0;
                        cmd_cnt_reg  <= 6'h00;
                        bit_cnt_reg  <= 8'h00;
                        word_cnt_reg <= 13'h0000;
                        shift_reg    <= 128'h0;
                        d_out[0]     <= read_cmd[7];
                        d_oe[0]      <= 1'b1;
                        busy         <= 1'b1;
                        state_reg    <= `ST_LEAD;
                    end
                end
                `ST_LEAD: begin
                    sclk   <= 1'b0;
                    // select drops one cycle after the take to match the registered sclk lag
                    cs_n   <= 1'b0;
                    ph_reg <= ph_inc;
                    // in dual and quad, one period before the first fall, hold lines 1..3 high
                    if (lead_cnt_reg == dly_reg && fall_tick && mode_reg[1]) begin
                        d_out[3:1] <= 3'h7;
                        d_oe[3:1]  <= 3'h7;
                    end
                    if (wrap) begin
                        if (lead_cnt_reg == dly_reg)
                            state_reg <= `ST_CMD;
                        else
                            lead_cnt_reg <= lead_cnt_reg + 2'h1;
                    end
                end
                `ST_CMD: begin
                    ph_reg <= ph_inc;
                    sclk   <= (ph_reg < hi_reg);
                    if (fall_tick) begin
                        cmd_sh_reg <= {cmd_sh_reg[30:0], 1'b0};
                        if (cmd_cnt_reg == `CMD_BITS - 6'h01) begin
                            d_oe      <= 4'h0;
                            d_out     <= 4'h0;
                            state_reg <= `ST_READ;
                        end else begin
                            cmd_cnt_reg <= cmd_cnt_reg + 6'h01;
                            d_out[0]    <= cmd_sh_reg[30];
                        end
                    end
                end
                `ST_READ: begin
                    ph_reg <= ph_inc;
                    sclk   <= (ph_reg < hi_reg);
                    if (fall_tick) begin
                        shift_reg <= shift_next;
                        if (bits_next >= {1'b0, len_reg} + 8'h01) begin
                            bit_cnt_reg <= 8'h00;
                            rdata       <= shift_next;
                            rdata_valid <= 1'b1;
                            word_irq    <= wirq_en_reg;
                            if (word_cnt_reg == {1'b0, count_reg}) begin
                                frame_irq    <= firq_en_reg;
                                tail_cnt_reg <= 2'h0;
                                state_reg    <= `ST_TAIL;
                            end else begin
                                word_cnt_reg <= word_cnt_reg + 13'h0001;
                            end
                        end else begin
                            bit_cnt_reg <= bits_next;
                        end
                    end
                end
                `ST_TAIL: begin
                    ph_reg <= ph_inc;
                    sclk   <= 1'b0;
                    if (fall_tick) begin
                        if (tail_cnt_reg == `TAIL_PERIODS - 2'h1) begin
                            cs_n      <= 1'b1;
                            busy      <= 1'b0;
                            ph_reg    <= 9'h000;
                            state_reg <= `ST_IDLE;
                        end else begin
                            tail_cnt_reg <= tail_cnt_reg + 2'h1;
                        end
                    end
                end
                default: begin
                    state_reg <= `ST_IDLE;
                end
            endcase
        end
    end
endmodule // flash_read_master

// >>> testbench/flash_read_master_assertions.sv
// assertions on the ports of the serial flash read master
module frm_checker (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       mm_req,
    input wire logic [7:0] clock_divide_factor,
    input wire logic [1:0] cs_to_data_delay_field,
    input wire logic       word_irq_en,
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic [3:0] d_out,
    input wire logic [3:0] d_oe,
    input wire logic       rdata_valid,
    input wire logic       word_irq,
    input wire logic       busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [11:0] lead_cnt, hi_cnt, tail_cnt, per, hi_exp;
    logic        sclk_q, fell_seen;
    assign per = (clock_divide_factor == 8'h00) ? 12'h002 : {4'h0, clock_divide_factor} + 12'h001;
    assign hi_exp = (clock_divide_factor == 8'h00) ? 12'h001 :
                    {5'h00, clock_divide_factor[7:1]} + {11'h000, clock_divide_factor[0]};
    // cycles since chip select fell, sclk high cycles, cycles since last sclk fall
    always @(posedge ref_clk) begin
        sclk_q    <= rst ? 1'b0 : sclk;
        lead_cnt  <= (rst || cs_n) ? 12'h000 : lead_cnt + 12'h001;
        hi_cnt    <= (rst || !sclk) ? 12'h000 : hi_cnt + 12'h001;
        tail_cnt  <= (rst || (sclk_q && !sclk)) ? 12'h001 : tail_cnt + 12'h001;
        fell_seen <= (rst || cs_n) ? 1'b0 : fell_seen | (sclk_q & ~sclk);
    end
    sequence s_take; mm_req && !busy; endsequence
    sequence s_launch; busy && d_oe[0] ##1 !cs_n && busy; endsequence
    property p_start; s_take |=> s_launch; endproperty
    property p_idle; !busy |-> cs_n && !sclk && d_oe == 4'h0; endproperty
    property p_clk_sel; sclk |-> !cs_n && busy; endproperty
    property p_d0; !cs_n && !$past(cs_n) && $changed(d_out[0]) |-> $fell(sclk); endproperty
    property p_lead;
        $fell(sclk) && !fell_seen |->
            lead_cnt == ({10'h000, cs_to_data_delay_field} + 12'h001) * per;
    endproperty
    property p_high; $fell(sclk) |-> hi_cnt == hi_exp; endproperty
    property p_tail; $rose(cs_n) |-> tail_cnt == 12'h002 * per; endproperty
    property p_irq; rdata_valid || word_irq |-> word_irq == (rdata_valid && word_irq_en); endproperty
    property p_read; rdata_valid |-> !cs_n && d_oe == 4'h0; endproperty
    a_start: assert property (p_start) else $error("request not taken");
    a_idle: assert property (p_idle) else $error("pins active while idle");
    a_clk_sel: assert property (p_clk_sel) else $error("sclk high outside frame");
    a_d0: assert property (p_d0) else $error("d0 moved off a falling edge");
    a_lead: assert property (p_lead) else $error("wrong select to first fall");
    a_high: assert property (p_high) else $error("wrong sclk high time");
    a_tail: assert property (p_tail) else $error("wrong select release");
    a_irq: assert property (p_irq) else $error("word event mismatch");
    a_read: assert property (p_read) else $error("lines driven while reading");
endmodule // frm_checker

bind flash_read_master frm_checker u_chk (.ref_clk, .rst, .mm_req, .clock_divide_factor,
    .cs_to_data_delay_field, .word_irq_en, .sclk, .cs_n, .d_out, .d_oe, .rdata_valid,
    .word_irq, .busy);

// >>> testbench/flash_model.sv
// serial flash model streaming a fixed pattern after the 32 command bits
module flash_model #(
    parameter logic [63:0] PATTERN = 64'hc3a5_96f0_1e2d_7b48
) (
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic [1:0] lane_mode,
    output logic      [3:0] d_drive
);
    timeunit 1ns;
    timeprecision 1ns;
    int falls = 0;
    int idx   = 0;
    function automatic logic sb(input int i);
        return PATTERN[63 - (i % 64)];
    endfunction
    initial d_drive = 4'h0;
    // released lines show the inverse of the last value
    always @(posedge cs_n) d_drive <= ~d_drive;
    always @(negedge cs_n) begin
        falls = 0;
        idx = 0;
    end
    always @(negedge sclk) begin
        if (!cs_n) begin
            falls = falls + 1;
            d_drive <= ~d_drive;
            if (falls >= 32) begin
                case (lane_mode)
                    2'h0: d_drive[0] <= sb(idx);
                    2'h1: d_drive[1] <= sb(idx);
                    2'h2: d_drive[1:0] <= {sb(idx), sb(idx + 1)};
                    default: d_drive <= {sb(idx), sb(idx + 1), sb(idx + 2), sb(idx + 3)};
                endcase
                idx = idx + (lane_mode == 2'h3 ? 4 : (lane_mode == 2'h2 ? 2 : 1));
            end
        end
    end
endmodule // flash_model

// >>> testbench/flash_read_master_test.sv
// self-checking bench for the serial flash read master
module flash_read_master_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] PATTERN = 64'hc3a5_96f0_1e2d_7b48;
    logic         ref_clk = 1'b0, rst = 1'b1, mm_req = 1'b0, word_irq_en = 1'b0;
    logic         frame_irq_en = 1'b0, sclk_prev = 1'b0;
    logic [23:0]  mm_addr = 24'h000000;
    logic [7:0]   read_cmd = 8'h00, clock_divide_factor = 8'h03;
    logic [1:0]   lane_mode = 2'h0, cs_to_data_delay_field = 2'h0;
    logic [6:0]   word_len_m1 = 7'h00;
    logic [11:0]  word_count_m1 = 12'h000;
    logic [3:0]   d_in, d_out, d_oe, flash_d;
    logic [127:0] rdata;
    logic         sclk, cs_n, rdata_valid, word_irq, frame_irq, busy;
    logic [31:0]  exp_cmd = 32'h0;
    int           miscompares = 0, comparisons = 0, nrise = 0;
    always #50 ref_clk = ~ref_clk;
    assign d_in = (d_oe & d_out) | (~d_oe & flash_d);
    flash_read_master DUT (.ref_clk, .rst, .mm_req, .mm_addr, .read_cmd, .lane_mode,
        .clock_divide_factor, .word_len_m1, .word_count_m1, .cs_to_data_delay_field,
        .word_irq_en, .frame_irq_en, .d_in, .sclk, .cs_n, .d_out, .d_oe, .rdata,
        .rdata_valid, .word_irq, .frame_irq, .busy);
    flash_model partner (.sclk, .cs_n, .lane_mode, .d_drive(flash_d));
    task automatic print_verdict;
        if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [127:0] got, input logic [127:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_for(input logic idle);
        for (int k = 0; k < 3000; k++) begin
            @(negedge ref_clk);
            if (idle ? busy === 1'b0 : rdata_valid === 1'b1) return;
        end
        miscompares++;
        print_verdict();
    endtask
    // command bits seen at each sclk rise, line 1 raised early in dual and quad
    always @(negedge ref_clk) begin
        if (cs_n) nrise = 0;
        else if (sclk && !sclk_prev) begin
            if (nrise < 32) chk_bit(d_out[0], exp_cmd[31 - nrise]);
            if (nrise == 0 && lane_mode[1]) chk_bit(d_out[1] & d_oe[1], 1'b1);
            nrise = nrise + 1;
        end
        sclk_prev = sclk;
    end
    task automatic run(input logic [7:0] c, input logic [1:0] m, input logic [7:0] f,
                       input logic [6:0] l, input logic [11:0] n, input logic [1:0] dd,
                       input logic wi, input logic fi);
        logic [127:0] e;
        @(posedge ref_clk);
        mm_req <= 1'b1;
        read_cmd <= c;
        mm_addr <= {c, ~c, c};
        lane_mode <= m;
        clock_divide_factor <= f;
        word_len_m1 <= l;
        word_count_m1 <= n;
        cs_to_data_delay_field <= dd;
        word_irq_en <= wi;
        frame_irq_en <= fi;
        exp_cmd = {c, c, ~c, c};
        @(posedge ref_clk);
        mm_req <= 1'b0;
        repeat (5) @(posedge ref_clk);
        mm_req <= 1'b1;
        read_cmd <= ~c;
        @(posedge ref_clk);
        mm_req <= 1'b0;
        for (int w = 0; w <= n; w++) begin
            wait_for(1'b0);
            e = '0;
            for (int b = 0; b <= l; b++) e[l - b] = PATTERN[63 - ((w * (l + 1) + b) % 64)];
            chk_word(rdata & ({128{1'b1}} >> (127 - l)), e);
            chk_bit(word_irq, wi);
            chk_bit(frame_irq, fi && w == n);
        end
        wait_for(1'b1);
        repeat (3) @(negedge ref_clk);
        chk_bit(cs_n, 1'b1);
        chk_bit(sclk, 1'b0);
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        run(8'h0b, 2'h0, 8'h07, 7'h07, 12'h001, 2'h0, 1'b1, 1'b1);
        run(8'h3b, 2'h1, 8'h04, 7'h00, 12'h002, 2'h3, 1'b1, 1'b0);
        run(8'hbb, 2'h2, 8'h05, 7'h0f, 12'h000, 2'h1, 1'b0, 1'b0);
        run(8'h6b, 2'h3, 8'h03, 7'h7f, 12'h001, 2'h2, 1'b0, 1'b1);
        print_verdict();
    end
endmodule // flash_read_master_test
